// ==== logic/cps_config_port.v ====
`timescale 1ns/1ps
`include "cps_config_map.vh"
module cps_config_port (
    input  wire clk,
    input  wire rst_b,
    input  wire config_serial_clock,
    input  wire config_chip_select_b,
    input  wire config_serial_in,
    input  wire dev_ready,
    input  wire four_wire_mode,
    input  wire sample_lane0_in,
    input  wire sample_lane0_oe_in,
    output reg  config_serial_out,
    output reg  config_serial_out_oe,
    output reg  sample_serial_out_lane0,
    output reg  sample_serial_out_lane0_oe,
    output reg  crc_check_active,
    output reg  serial_port_error
);
    wire [2:0]  pin_q;
    wire [2:0]  pin_q_d;
    reg  [7:0]  loop_size_reg;
    reg  [7:0]  loop_ctrl_reg;
    reg  [7:0]  crc_cfg_reg;
    reg  [7:0]  status_reg;
    reg  [7:0]  status_next;
    reg  [7:0]  pin_sel_reg;
    reg         act_reg;
    reg         instr_done_reg;
    reg         rd_reg;
    reg         crc_ph_reg;
    reg         any_byte_reg;
    reg  [3:0]  cnt_reg;
    reg  [15:0] shin_reg;
    reg  [7:0]  hold_reg;
    reg  [7:0]  shout_reg;
    reg         out_bit_reg;
    reg  [7:0]  loop_cnt_reg;
    reg  [`CPS_ADDR_W-1:0] addr_reg;
    reg  [`CPS_ADDR_W-1:0] start_reg;
    reg  [`CPS_ADDR_W-1:0] addr_next;
    reg  [15:0] sh_next;
    reg  [7:0]  wdata;
    reg  [7:0]  st_set;
    reg  [7:0]  st_clr;
    reg         bit_ev;
    reg         byte_done;
    reg         acc_done;
    reg         crc_bad;
    reg         commit;
    reg         crc_on;
    reg         wrap;

    cps_pin_sync #(
        .W (3)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({config_serial_in, ~config_chip_select_b, config_serial_clock}),
        .q     (pin_q),
        .q_d   (pin_q_d)
    );

    wire sck_rise = pin_q[0] & ~pin_q_d[0];
    wire sck_fall = ~pin_q[0] & pin_q_d[0];
    // Select synced active high, reset level is idle
    wire cs_fall  = pin_q[1] & ~pin_q_d[1];
    wire cs_rise  = ~pin_q[1] & pin_q_d[1];
    wire sdi      = pin_q[2];

    function is_def;
        input [`CPS_ADDR_W-1:0] a;
        begin
            is_def = (a == `CPS_ADDR_LOOP_SIZE) || (a == `CPS_ADDR_LOOP_CTRL) ||
                     (a == `CPS_ADDR_CRC_CFG) || (a == `CPS_ADDR_ERR_STATUS) ||
                     (a == `CPS_ADDR_PIN_SEL) || (a == `CPS_ADDR_DEV_STATUS);
        end
    endfunction

    function is_ro;
        input [`CPS_ADDR_W-1:0] a;
        begin
            is_ro = (a == `CPS_ADDR_DEV_STATUS);
        end
    endfunction

    // Register read image
    function [7:0] rd_val;
        input [`CPS_ADDR_W-1:0] a;
        begin
            case (a)
                `CPS_ADDR_LOOP_SIZE:  rd_val = loop_size_reg;
                `CPS_ADDR_LOOP_CTRL:  rd_val = loop_ctrl_reg;
                `CPS_ADDR_CRC_CFG:    rd_val = crc_cfg_reg;
                `CPS_ADDR_ERR_STATUS: rd_val = status_reg;
                `CPS_ADDR_PIN_SEL:    rd_val = pin_sel_reg;
                // RL10 error summary
                `CPS_ADDR_DEV_STATUS: rd_val = {4'h0, |status_reg, 3'h0};
                default:              rd_val = 8'h00;
            endcase
        end
    endfunction

    function [7:0] crc8;
        input [15:0] d;
        integer i;
        reg [7:0] c;
        begin
            c = 8'h00;
            for (i = 15; i >= 0; i = i - 1)
            begin
                if (c[7] ^ d[i])
                    c = {c[6:0], 1'b0} ^ `CPS_CRC_POLY;
                else
                    c = {c[6:0], 1'b0};
            end
            crc8 = c;
        end
    endfunction

    always @*
    begin
        // RL2 enable pair
        crc_on    = (crc_cfg_reg[`CPS_CRC_EN_HI:`CPS_CRC_EN_LO] == `CPS_CRC_EN_ON) &&
                    (crc_cfg_reg[`CPS_CRC_EN_N_HI:`CPS_CRC_EN_N_LO] == `CPS_CRC_EN_N_ON);
        sh_next   = {shin_reg[14:0], sdi};
        bit_ev    = act_reg & sck_rise;
        byte_done = bit_ev & instr_done_reg & (cnt_reg == `CPS_BYTE_LAST);
        acc_done  = byte_done & (crc_on ? crc_ph_reg : 1'b1);
        wdata     = crc_on ? hold_reg : sh_next[7:0];
        // RL5 checksum compare
        crc_bad   = byte_done & crc_on & crc_ph_reg &
                    (sh_next[7:0] != crc8({addr_reg[7:0], hold_reg}));
        commit    = acc_done & ~rd_reg & ~crc_bad & is_def(addr_reg) & ~is_ro(addr_reg);
        // RL9 loop back to start
        wrap      = (loop_size_reg != 8'h00) && ((loop_cnt_reg + 8'h01) == loop_size_reg);
        addr_next = wrap ? start_reg : addr_reg + 15'h0001;
        st_set    = 8'h00;
        // RL7 undefined address
        st_set[`CPS_ST_BAD_ADDR]     = acc_done & ~is_def(addr_reg);
        // RL6 read-only write
        st_set[`CPS_ST_RO_WRITE]     = acc_done & ~rd_reg & is_ro(addr_reg);
        st_set[`CPS_ST_CRC_MISMATCH] = crc_bad;
        // RL4 edge tally
        st_set[`CPS_ST_EDGE_COUNT]   = cs_rise & act_reg & (~instr_done_reg | ~any_byte_reg |
                                       (cnt_reg != 4'h0) | crc_ph_reg);
        // RL3 early access
        st_set[`CPS_ST_NOT_READY]    = cs_fall & ~dev_ready;
        st_clr = 8'h00;
        if (commit && (addr_reg == `CPS_ADDR_ERR_STATUS))
            st_clr = wdata & `CPS_ST_W1C_MASK;
        // Set wins over clear
        status_next = (status_reg & ~st_clr) | st_set;
        if (commit && (addr_reg == `CPS_ADDR_ERR_STATUS))
            status_next[`CPS_ST_EDGE_COUNT] = wdata[`CPS_ST_EDGE_COUNT] |
                                              st_set[`CPS_ST_EDGE_COUNT];
        status_next = status_next & `CPS_ST_USED_MASK;
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loop_size_reg  <= `CPS_RST_LOOP_SIZE;
            loop_ctrl_reg  <= `CPS_RST_LOOP_CTRL;
            crc_cfg_reg    <= `CPS_RST_CRC_CFG;
            status_reg     <= `CPS_RST_ERR_STATUS;
            pin_sel_reg    <= `CPS_RST_PIN_SEL;
            act_reg        <= 1'b0;
            instr_done_reg <= 1'b0;
            rd_reg         <= 1'b0;
            crc_ph_reg     <= 1'b0;
            any_byte_reg   <= 1'b0;
            cnt_reg        <= 4'h0;
            shin_reg       <= 16'h0000;
            hold_reg       <= 8'h00;
            shout_reg      <= 8'h00;
            out_bit_reg    <= 1'b0;
            loop_cnt_reg   <= 8'h00;
            addr_reg       <= 15'h0000;
            start_reg      <= 15'h0000;
        end
        else
        begin
            status_reg <= status_next;
            // RL11 reserved bits kept zero
            if (commit)
            begin
                case (addr_reg)
                    `CPS_ADDR_LOOP_SIZE: loop_size_reg <= wdata;
                    `CPS_ADDR_LOOP_CTRL: loop_ctrl_reg <= wdata & 8'h04;
                    `CPS_ADDR_CRC_CFG:   crc_cfg_reg   <= wdata & 8'hC3;
                    `CPS_ADDR_PIN_SEL:   pin_sel_reg   <= wdata & 8'h01;
                    default:             loop_size_reg <= loop_size_reg;
                endcase
            end
            if (bit_ev)
            begin
                shin_reg <= sh_next;
                if (!instr_done_reg)
                begin
                    if (cnt_reg == `CPS_INSTR_LAST)
                    begin
                        instr_done_reg <= 1'b1;
                        rd_reg         <= sh_next[15];
                        addr_reg       <= sh_next[14:0];
                        start_reg      <= sh_next[14:0];
                        shout_reg      <= sh_next[15] ? rd_val(sh_next[14:0]) : 8'h00;
                        cnt_reg        <= 4'h0;
                    end
                    else
                        cnt_reg <= cnt_reg + 4'h1;
                end
                else if (cnt_reg == `CPS_BYTE_LAST)
                begin
                    cnt_reg <= 4'h0;
                    if (crc_on && !crc_ph_reg)
                    begin
                        crc_ph_reg <= 1'b1;
                        hold_reg   <= sh_next[7:0];
                        shout_reg  <= 8'h00;
                    end
                    else
                    begin
                        crc_ph_reg   <= 1'b0;
                        any_byte_reg <= 1'b1;
                        addr_reg     <= addr_next;
                        loop_cnt_reg <= wrap ? 8'h00 : loop_cnt_reg + 8'h01;
                        shout_reg    <= rd_reg ? rd_val(addr_next) : 8'h00;
                    end
                end
                else
                    cnt_reg <= cnt_reg + 4'h1;
            end
            if (act_reg && sck_fall && instr_done_reg && rd_reg)
            begin
                out_bit_reg <= shout_reg[7];
                shout_reg   <= {shout_reg[6:0], 1'b0};
            end
            if (cs_fall)
            begin
                act_reg        <= dev_ready;
                instr_done_reg <= 1'b0;
                rd_reg         <= 1'b0;
                crc_ph_reg     <= 1'b0;
                any_byte_reg   <= 1'b0;
                cnt_reg        <= 4'h0;
                loop_cnt_reg   <= 8'h00;
                out_bit_reg    <= 1'b0;
            end
            if (cs_rise)
            begin
                act_reg <= 1'b0;
                // RL1 loop length clear
                if (act_reg && any_byte_reg && !loop_ctrl_reg[`CPS_KEEP_LOOP_BIT])
                    loop_size_reg <= 8'h00;
            end
        end
    end

    wire rd_drive = act_reg & instr_done_reg & rd_reg & four_wire_mode;
    wire on_lane0 = pin_sel_reg[`CPS_OUT_SEL_BIT];

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            config_serial_out          <= 1'b0;
            config_serial_out_oe       <= 1'b0;
            sample_serial_out_lane0    <= 1'b0;
            sample_serial_out_lane0_oe <= 1'b0;
            crc_check_active           <= 1'b0;
            serial_port_error          <= 1'b0;
        end
        else
        begin
            // RL8 readback pin choice
            config_serial_out          <= out_bit_reg & ~on_lane0;
            config_serial_out_oe       <= rd_drive & ~on_lane0;
            sample_serial_out_lane0    <= (rd_drive & on_lane0) ? out_bit_reg : sample_lane0_in;
            sample_serial_out_lane0_oe <= (rd_drive & on_lane0) | sample_lane0_oe_in;
            crc_check_active           <= crc_on;
            serial_port_error          <= |status_reg;
        end
    end
endmodule

// ==== logic/cps_config_map.vh ====
// What this block does
// RL1: With the retain bit at 0 the loop length is cleared on chip-select rise ending a stream.
// RL2: CRC checking is on only while the enable field is 0x1 and the inverted field is 0x2.
// RL3: A frame started before the device is ready sets status bit 7, cleared by writing 1.
// RL4: A frame with a wrong number of clock edges sets status bit 4, a plain read/write bit.
// RL5: With CRC on, a received checksum that mismatches sets status bit 3, cleared by 1.
// RL6: A write to a register holding only read-only bits sets status bit 2, cleared by 1.
// RL7: Access to an undefined address sets status bit 0, cleared by writing 1.
// RL8: In 4-wire mode read data leaves on the config output pin, or on lane 0 when selected.
// RL9: A nonzero loop length returns streaming to the start address after that many bytes.
// RL10: The main status register shows the OR of all serial port status bits.
// RL11: Reserved bits read as zero and writes to them change nothing.
`ifndef CPS_CONFIG_MAP_VH
`define CPS_CONFIG_MAP_VH

`define CPS_ADDR_W            15
`define CPS_ADDR_LOOP_SIZE    15'h000E
`define CPS_ADDR_LOOP_CTRL    15'h000F
`define CPS_ADDR_CRC_CFG      15'h0010
`define CPS_ADDR_ERR_STATUS   15'h0011
`define CPS_ADDR_PIN_SEL      15'h0014
`define CPS_ADDR_DEV_STATUS   15'h0020

`define CPS_RST_LOOP_SIZE     8'h00
`define CPS_RST_LOOP_CTRL     8'h00
`define CPS_RST_CRC_CFG       8'h03
`define CPS_RST_ERR_STATUS    8'h00
`define CPS_RST_PIN_SEL       8'h00

`define CPS_KEEP_LOOP_BIT     2
`define CPS_CRC_EN_HI         7
`define CPS_CRC_EN_LO         6
`define CPS_CRC_EN_N_HI       1
`define CPS_CRC_EN_N_LO       0
`define CPS_CRC_EN_ON         2'h1
`define CPS_CRC_EN_N_ON       2'h2
`define CPS_OUT_SEL_BIT       0
`define CPS_DEV_SPI_FLAG_BIT  3

`define CPS_ST_NOT_READY      7
`define CPS_ST_EDGE_COUNT     4
`define CPS_ST_CRC_MISMATCH   3
`define CPS_ST_RO_WRITE       2
`define CPS_ST_BAD_ADDR       0
`define CPS_ST_W1C_MASK       8'h8D
`define CPS_ST_USED_MASK      8'h9D

`define CPS_CRC_POLY          8'h07
`define CPS_INSTR_LAST        4'hF
`define CPS_BYTE_LAST         4'h7

`endif

// ==== logic/cps_pin_sync.v ====
`timescale 1ns/1ps
module cps_pin_sync #(
    parameter W = 3
) (
    input  wire         clk,
    input  wire         rst_b,
    input  wire [W-1:0] din,
    output reg  [W-1:0] q,
    output reg  [W-1:0] q_d
);
    reg [W-1:0] meta_reg;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= {W{1'b0}};
            q        <= {W{1'b0}};
            q_d      <= {W{1'b0}};
        end
        else
        begin
            meta_reg <= din;
            q        <= meta_reg;
            q_d      <= q;
        end
    end
endmodule

// ==== testbench/cps_spi_host.sv ====
`timescale 1ns/1ps
module cps_spi_host (
    input  logic clk,
    input  logic miso,
    output logic sck,
    output logic cs_b,
    output logic mosi
);
    initial
    begin
        sck = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
    end
    // One frame, MSB first, 8 clk per bit; reply sampled late in the high phase
    task automatic xfer(input logic [47:0] bits, input int n, output logic [23:0] rd);
        int i;
        rd = 24'h000000;
        @(posedge clk);
        cs_b <= 1'b0;
        mosi <= bits[n - 1];
        for (i = n - 1; i >= 0; i--)
        begin
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk);
            rd = {rd[22:0], miso};
            @(posedge clk);
            sck <= 1'b0;
            if (i > 0)
                mosi <= bits[i - 1];
        end
        repeat (4) @(posedge clk);
        cs_b <= 1'b1;
        // Released line must not keep its last level
        mosi <= ~mosi;
        repeat (10) @(posedge clk);
        @(negedge clk);
    endtask
endmodule

// ==== testbench/cps_config_port_checker.sv ====
`timescale 1ns/1ps
module cps_config_port_checker (
    input logic clk,
    input logic rst_b,
    input logic config_chip_select_b,
    input logic dev_ready,
    input logic four_wire_mode,
    input logic sample_lane0_in,
    input logic sample_lane0_oe_in,
    input logic config_serial_out_oe,
    input logic sample_serial_out_lane0,
    input logic sample_serial_out_lane0_oe,
    input logic crc_check_active,
    input logic serial_port_error
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    AST_OE_START: assert property (
        $rose(config_serial_out_oe) |-> four_wire_mode && !$past(config_chip_select_b, 2))
        else $error("readback enable rose outside a 4-wire frame");
    AST_OE_END: assert property (
        config_chip_select_b [*8] |-> !config_serial_out_oe)
        else $error("readback pin still driven after frame end");
    AST_LANE_DATA: assert property (
        config_chip_select_b [*8] |-> sample_serial_out_lane0 == $past(sample_lane0_in))
        else $error("lane 0 data does not follow sample data");
    AST_LANE_OE: assert property (
        config_chip_select_b [*8] |-> sample_serial_out_lane0_oe == $past(sample_lane0_oe_in))
        else $error("lane 0 enable does not follow sample enable");
    AST_ONE_PIN: assert property (
        config_serial_out_oe && !$past(sample_lane0_oe_in) |-> !sample_serial_out_lane0_oe)
        else $error("readback driven on both pins");
    AST_CRC_IDLE: assert property (
        config_chip_select_b [*6] |-> $stable(crc_check_active))
        else $error("crc enable changed outside a frame");
    AST_ERR_IDLE: assert property (
        config_chip_select_b [*8] |-> $stable(serial_port_error))
        else $error("error summary changed long after frame end");
    AST_NOT_READY: assert property (
        !dev_ready |-> !$rose(config_serial_out_oe))
        else $error("readback started while not ready");
    AST_MODE_OFF: assert property (
        !$past(four_wire_mode) |-> !config_serial_out_oe &&
            sample_serial_out_lane0_oe == $past(sample_lane0_oe_in))
        else $error("readback enabled outside 4-wire mode");
endmodule
bind cps_config_port cps_config_port_checker chk_u (
    .clk(clk), .rst_b(rst_b), .config_chip_select_b(config_chip_select_b),
    .dev_ready(dev_ready), .four_wire_mode(four_wire_mode),
    .sample_lane0_in(sample_lane0_in), .sample_lane0_oe_in(sample_lane0_oe_in),
    .config_serial_out_oe(config_serial_out_oe),
    .sample_serial_out_lane0(sample_serial_out_lane0),
    .sample_serial_out_lane0_oe(sample_serial_out_lane0_oe),
    .crc_check_active(crc_check_active), .serial_port_error(serial_port_error)
);

// ==== testbench/config_port_control_status_test.sv ====
`timescale 1ns/1ps
module config_port_control_status_test;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        dev_ready = 1'b1;
    logic        four_wire_mode = 1'b1;
    logic        lane_in = 1'b0;
    logic        lane_oe_in = 1'b0;
    logic        sel = 1'b0;
    logic        sck, cs_b, mosi, cso, cso_oe, lane_out, lane_oe, crc_on, spe;
    logic [23:0] rd;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          oe_cnt = 0;
    int          oe_base;
    int          i;
    // Row: {crc flag, address, write data, read back}
    logic [31:0] rows [0:7] = '{32'h000FFF04, 32'h000F0000, 32'h0014FE00, 32'h00104343,
                                32'h00104141, 32'h00108282, 32'h0010FEC2, 32'h00100303};
    logic [23:0] rst_rows [0:4] = '{24'h000E00, 24'h000F00, 24'h001003, 24'h001100, 24'h001400};

    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        lane_in <= ~lane_in;
        lane_oe_in <= lane_in;
        if (cso_oe)
            oe_cnt <= oe_cnt + 1;
    end

    cps_spi_host host_u (.clk(clk), .miso(sel ? lane_out : cso), .sck(sck), .cs_b(cs_b),
        .mosi(mosi));
    cps_config_port dut_u (.clk(clk), .rst_b(rst_b), .config_serial_clock(sck),
        .config_chip_select_b(cs_b), .config_serial_in(mosi), .dev_ready(dev_ready),
        .four_wire_mode(four_wire_mode), .sample_lane0_in(lane_in),
        .sample_lane0_oe_in(lane_oe_in), .config_serial_out(cso), .config_serial_out_oe(cso_oe),
        .sample_serial_out_lane0(lane_out), .sample_serial_out_lane0_oe(lane_oe),
        .crc_check_active(crc_on), .serial_port_error(spe));

    task automatic chk(input string what, input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host_u.xfer({24'h000000, 1'b0, a, d}, 24, rd);
    endtask
    task automatic rdc(input logic [14:0] a, input logic [7:0] e);
        host_u.xfer({24'h000000, 1'b1, a, 8'h00}, 24, rd);
        chk("read", rd[7:0], e);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #1000000;
        n_fail++;
        report_and_stop;
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        for (i = 0; i < 8; i++)
        begin
            wr(rows[i][30:16], rows[i][15:8]);
            chk("crc_active", crc_on, rows[i][31]);
            rdc(rows[i][30:16], rows[i][7:0]);
        end
        // Error flags: set, summary, clear
        wr(15'h0012, 8'h55);
        rdc(15'h0011, 8'h01);
        chk("error_out", spe, 1'b1);
        rdc(15'h0020, 8'h08);
        wr(15'h0011, 8'hFF);
        rdc(15'h0011, 8'h10);
        wr(15'h0011, 8'h00);
        rdc(15'h0011, 8'h00);
        chk("error_out", spe, 1'b0);
        wr(15'h0020, 8'hFF);
        rdc(15'h0011, 8'h04);
        wr(15'h0011, 8'h04);
        host_u.xfer({28'h0000000, 1'b0, 15'h000F, 4'h0}, 20, rd);
        rdc(15'h0011, 8'h10);
        wr(15'h0011, 8'h00);
        @(posedge clk);
        dev_ready <= 1'b0;
        wr(15'h0014, 8'h01);
        @(posedge clk);
        dev_ready <= 1'b1;
        rdc(15'h0011, 8'h80);
        rdc(15'h0014, 8'h00);
        wr(15'h0011, 8'h80);
        // Looped stream, then loop length clear
        wr(15'h000F, 8'h04);
        wr(15'h000E, 8'h02);
        host_u.xfer({8'h00, 1'b1, 15'h0010, 24'h000000}, 40, rd);
        chk("stream", rd, 24'h030003);
        rdc(15'h000E, 8'h02);
        wr(15'h000F, 8'h00);
        rdc(15'h000E, 8'h00);
        wr(15'h0014, 8'h01);
        sel = 1'b1;
        rdc(15'h0010, 8'h03);
        sel = 1'b0;
        wr(15'h0014, 8'h00);
        // Readback pin not driven outside 4-wire mode
        oe_base = oe_cnt;
        chk("readback_oe_seen", oe_base > 0, 1'b1);
        @(posedge clk);
        four_wire_mode <= 1'b0;
        host_u.xfer({24'h000000, 1'b1, 15'h0010, 8'h00}, 24, rd);
        chk("readback_oe", 24'(oe_cnt - oe_base), 24'h000000);
        @(posedge clk);
        four_wire_mode <= 1'b1;
        // Checksum on, bad checksum byte
        wr(15'h0010, 8'h42);
        chk("crc_active", crc_on, 1'b1);
        host_u.xfer({16'h0000, 16'h000F, 8'h04, 8'h00}, 32, rd);
        host_u.xfer({16'h0000, 16'h8011, 16'h0000}, 32, rd);
        chk("status", rd[15:8], 8'h08);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        chk("crc_active", crc_on, 1'b0);
        for (i = 0; i < 5; i++)
            rdc(rst_rows[i][22:8], rst_rows[i][7:0]);
        chk("error_out", spe, 1'b0);
        report_and_stop;
    end
endmodule
